// file: guard_pkg.sv
// Package of constants and frame type for node life guarding
`default_nettype none
package guard_pkg;
	typedef struct packed {
		logic [10:0] id;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
	} can_frame_t;
	typedef enum logic [1:0] {W8, W16, W32} size_t;
	localparam int CLK_NS = 8;
	localparam int MS_NS = 1_000_000;
	localparam int CYC_PER_MS = MS_NS / CLK_NS;
	localparam logic [15:0] IDX_ERR_FLAGS = 16'h1001;
	localparam logic [15:0] IDX_ERR_HIST = 16'h1003;
	localparam logic [15:0] IDX_PDO_CNT = 16'h1004;
	localparam logic [15:0] IDX_SYNC_ID = 16'h1005;
	localparam logic [15:0] IDX_STATION = 16'h100b;
	localparam logic [15:0] IDX_POLL_IVL = 16'h100c;
	localparam logic [15:0] IDX_MULT = 16'h100d;
	localparam logic [15:0] IDX_GUARD_ID = 16'h100e;
	localparam logic [15:0] IDX_SDO_CNT = 16'h100f;
	localparam logic [15:0] IDX_ALARM_ID = 16'h1014;
	localparam logic [7:0] ERR_HIST_RST = 8'h0a;
	localparam logic [7:0] PDO_SUB_MAX = 8'h02;
	localparam logic [31:0] PDO_CNT_RST = 32'h0005_000a;
	localparam logic [31:0] SYNC_ID_RST = 32'h0000_0080;
	localparam logic [15:0] POLL_IVL_RST = 16'h03e8;
	localparam logic [7:0] MULT_RST = 8'h03;
	localparam logic [31:0] SDO_CNT_RST = 32'h0001_0001;
	localparam logic [10:0] GUARD_BASE = 11'h700;
	localparam logic [10:0] ALARM_BASE = 11'h080;
	localparam logic [10:0] SDO_RX_BASE = 11'h600;
	localparam logic [10:0] SDO_TX_BASE = 11'h580;
	localparam logic [6:0] ST_PREOP = 7'h04;
	localparam logic [6:0] ST_OPER = 7'h05;
	localparam logic [63:0] ALARM_DATA = 64'h0000_0010_0001_0010;
	localparam logic [3:0] SDO_DLC = 4'h8;
	localparam logic [3:0] GUARD_DLC = 4'h1;
	localparam logic [7:0] CMD_RD = 8'h40;
	localparam logic [7:0] CMD_WR8 = 8'h2f;
	localparam logic [7:0] CMD_WR16 = 8'h2b;
	localparam logic [7:0] CMD_WR32 = 8'h23;
	localparam logic [7:0] RSP_WR = 8'h60;
	localparam logic [7:0] RSP_RD8 = 8'h4f;
	localparam logic [7:0] RSP_RD16 = 8'h4b;
	localparam logic [7:0] RSP_RD32 = 8'h43;
	localparam logic [7:0] RSP_ABORT = 8'h80;
	localparam logic [31:0] ABORT_NO_OBJ = 32'h0602_0000;
	localparam logic [31:0] ABORT_RO = 32'h0601_0002;
	localparam logic [31:0] ABORT_CMD = 32'h0504_0001;
	localparam int ERR_GEN_BIT = 0;
	localparam int ERR_COMM_BIT = 4;
endpackage
`default_nettype wire

// file: node_life_guarding.sv
// Node guarding responder, master supervision and comm objects
// Summary of operation
// - A remote frame on the guarding id is answered with state and toggle.
// - The reply state code is 4 in pre-operational and 5 in operational.
// - The toggle is bit 7, 0 in the first reply and after a timeout, inverted in every next.
// - Timeout in ms is the poll interval times the timeout multiplier.
// - A zero interval or zero multiplier switches supervision off.
// - Supervision starts at the first poll; each later poll is timed.
// - On timeout the outputs go to error status and an alarm is sent.
// - The alarm frame holds 10 00 01 00 10 00 00 00 on the alarm id.
// - After a timeout a fresh poll resumes answering and supervision.
// - The guarding id is 0x700 plus station number unless rewritten.
// - The alarm id is a 32-bit rw entry, default 0x80 plus station.
// - Each entry is addressed by a 16-bit index and 8-bit subindex.
// - Entries are read and written by 8-byte SDO frames.
`timescale 1ns/1ns
`default_nettype none
module node_life_guarding import guard_pkg::*; #(
	parameter int CYC_MS = CYC_PER_MS
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [6:0] station_number,
	input wire logic operational,
	input wire logic rx_valid,
	input wire can_frame_t rx_frame,
	output logic tx_valid,
	input wire logic tx_ready,
	output can_frame_t tx_frame,
	output logic outputs_error,
	output logic guarding_active
);
	typedef enum logic [1:0] {G_IDLE, G_WATCH, G_LOST} gstate_t;

	function automatic can_frame_t mk_frame(input logic [10:0] id,
		input logic [3:0] dlc, input logic [63:0] data);
		can_frame_t f;
		f.id = id;
		f.rtr = 1'b0;
		f.dlc = dlc;
		f.data = data;
		return f;
	endfunction

	function automatic logic [63:0] sdo_abort(input logic [23:0] at,
		input logic [31:0] code);
		return {code, at, RSP_ABORT};
	endfunction

	gstate_t g_q;
	logic [31:0] pre_q;
	logic [23:0] ms_q;
	logic toggle_q, oerr_q;
	logic gp_q, sp_q, ap_q, tx_valid_q;
	can_frame_t tx_frame_q;
	logic [63:0] sdo_rsp_q;
	logic [31:0] sync_q, guard_cob_q, alarm_cob_q;
	logic guard_set_q, alarm_set_q;
	logic [15:0] poll_ivl_q;
	logic [7:0] mult_q;
	logic [10:0] guard_id, alarm_id, sdo_rx_id, sdo_tx_id;
	logic [23:0] life_ms;
	logic poll, sdo_req, sup_on, expire;
	logic ld_a, ld_g, ld_s;
	logic [15:0] idx;
	logic [7:0] sub, cmd;
	logic [31:0] wval, rd_val;
	logic [7:0] err_flags;
	size_t rd_w;
	logic hit, rw, is_wr;
	logic [6:0] code;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Identifiers, rewritten values override the station defaults
	assign guard_id = guard_set_q ? guard_cob_q[10:0]
		: GUARD_BASE + {4'h0, station_number};
	assign alarm_id = alarm_set_q ? alarm_cob_q[10:0]
		: ALARM_BASE + {4'h0, station_number};
	assign sdo_rx_id = SDO_RX_BASE + {4'h0, station_number};
	assign sdo_tx_id = SDO_TX_BASE + {4'h0, station_number};

	// Incoming frame classification
	assign poll = rx_valid && rx_frame.rtr
		&& rx_frame.id == guard_id;
	assign sdo_req = rx_valid && !rx_frame.rtr && rx_frame.id == sdo_rx_id
		&& rx_frame.dlc == SDO_DLC;
	assign cmd = rx_frame.data[7:0];
	assign idx = rx_frame.data[23:8];
	assign sub = rx_frame.data[31:24];
	assign wval = rx_frame.data[63:32];
	assign is_wr = cmd == CMD_WR8 || cmd == CMD_WR16 || cmd == CMD_WR32;

	// Supervision window in ms
	assign life_ms = 24'(poll_ivl_q) * 24'(mult_q);
	assign sup_on = poll_ivl_q != 16'h0000 && mult_q != 8'h00;
	assign expire = g_q == G_WATCH && sup_on && ms_q >= life_ms
		&& !poll;

	// Guarding state: idle until first poll, watched, or lost
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			g_q <= G_IDLE;
		end else begin
			case (g_q)
				G_IDLE: begin
					if (poll) g_q <= G_WATCH;
				end
				G_WATCH: begin
					if (expire) g_q <= G_LOST;
				end
				G_LOST: begin
					if (poll) g_q <= G_WATCH;
				end
				default: g_q <= G_IDLE;
			endcase
		end
	end

	// Millisecond prescaler and elapsed-ms counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_q <= '0;
			ms_q <= '0;
		end else if (poll || g_q != G_WATCH || !sup_on) begin
			pre_q <= '0;
			ms_q <= '0;
		end else if (pre_q == 32'(CYC_MS - 1)) begin
			pre_q <= '0;
			ms_q <= ms_q + 24'h00_0001;
		end else begin
			pre_q <= pre_q + 32'h0000_0001;
		end
	end

	// Toggle bit flips per reply sent, cleared by a timeout
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			toggle_q <= 1'b0;
		end else if (expire) begin
			toggle_q <= 1'b0;
		end else if (ld_g) begin
			toggle_q <= !toggle_q;
		end
	end

	// Outputs forced to error status until guarding resumes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			oerr_q <= 1'b0;
		end else if (expire) begin
			oerr_q <= 1'b1;
		end else if (poll && g_q == G_LOST) begin
			oerr_q <= 1'b0;
		end
	end

	// Transmit loader: alarm first, then guard reply, then SDO answer
	assign ld_a = !tx_valid_q && ap_q;
	assign ld_g = !tx_valid_q && !ap_q && gp_q;
	assign ld_s = !tx_valid_q && !ap_q && !gp_q && sp_q;

	// Pending requests, a new request wins over the load
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ap_q <= 1'b0;
			gp_q <= 1'b0;
			sp_q <= 1'b0;
		end else begin
			ap_q <= expire || (ap_q && !ld_a);
			gp_q <= poll || (gp_q && !ld_g);
			sp_q <= sdo_req || (sp_q && !ld_s);
		end
	end

	assign code = operational ? ST_OPER : ST_PREOP;

	// Output frame register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_valid_q <= 1'b0;
			tx_frame_q <= '0;
		end else if (tx_valid_q) begin
			if (tx_ready) tx_valid_q <= 1'b0;
		end else if (ld_a) begin
			tx_valid_q <= 1'b1;
			tx_frame_q <= mk_frame(alarm_id, SDO_DLC, ALARM_DATA);
		end else if (ld_g) begin
			tx_valid_q <= 1'b1;
			tx_frame_q <= mk_frame(guard_id, GUARD_DLC,
				{56'h0, toggle_q, code});
		end else if (ld_s) begin
			tx_valid_q <= 1'b1;
			tx_frame_q <= mk_frame(sdo_tx_id, SDO_DLC, sdo_rsp_q);
		end
	end

	assign err_flags = (8'(oerr_q) << ERR_COMM_BIT)
		| (8'(oerr_q) << ERR_GEN_BIT);

	// Object lookup by index and subindex
	always_comb begin
		rd_val = '0;
		rd_w = W32;
		hit = sub == 8'h00;
		rw = 1'b0;
		case (idx)
			IDX_ERR_FLAGS: begin
				rd_val = {24'h0, err_flags};
				rd_w = W8;
			end
			IDX_ERR_HIST: begin
				hit = sub <= ERR_HIST_RST;
				if (sub == 8'h00) rd_w = W8;
				rd_val = sub == 8'h00 ? {24'h0, ERR_HIST_RST} : '0;
			end
			IDX_PDO_CNT: begin
				hit = sub <= PDO_SUB_MAX;
				rd_val = PDO_CNT_RST;
			end
			IDX_SYNC_ID: begin
				rd_val = sync_q;
				rw = 1'b1;
			end
			IDX_STATION: rd_val = {25'h0, station_number};
			IDX_POLL_IVL: begin
				rd_val = {16'h0, poll_ivl_q};
				rd_w = W16;
				rw = 1'b1;
			end
			IDX_MULT: begin
				rd_val = {24'h0, mult_q};
				rd_w = W8;
				rw = 1'b1;
			end
			IDX_GUARD_ID: begin
				rd_val = guard_set_q ? guard_cob_q : {21'h0, guard_id};
				rw = 1'b1;
			end
			IDX_SDO_CNT: rd_val = SDO_CNT_RST;
			IDX_ALARM_ID: begin
				rd_val = alarm_set_q ? alarm_cob_q : {21'h0, alarm_id};
				rw = 1'b1;
			end
			default: hit = 1'b0;
		endcase
	end

	// SDO answer built when the request arrives
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sdo_rsp_q <= '0;
		end else if (sdo_req) begin
			if (!hit)
				sdo_rsp_q <= sdo_abort({sub, idx}, ABORT_NO_OBJ);
			else if (cmd == CMD_RD)
				sdo_rsp_q <= {rd_val, sub, idx, rd_w == W8 ? RSP_RD8
					: rd_w == W16 ? RSP_RD16 : RSP_RD32};
			else if (is_wr && rw)
				sdo_rsp_q <= {32'h0, sub, idx, RSP_WR};
			else if (is_wr)
				sdo_rsp_q <= sdo_abort({sub, idx}, ABORT_RO);
			else
				sdo_rsp_q <= sdo_abort({sub, idx}, ABORT_CMD);
		end
	end

	// Writable communication objects
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_q <= SYNC_ID_RST;
			poll_ivl_q <= POLL_IVL_RST;
			mult_q <= MULT_RST;
			guard_cob_q <= '0;
			alarm_cob_q <= '0;
			guard_set_q <= 1'b0;
			alarm_set_q <= 1'b0;
		end else if (sdo_req && is_wr && hit && rw) begin
			case (idx)
				IDX_SYNC_ID: sync_q <= wval;
				IDX_POLL_IVL: poll_ivl_q <= wval[15:0];
				IDX_MULT: mult_q <= wval[7:0];
				IDX_GUARD_ID: begin
					guard_cob_q <= wval;
					guard_set_q <= 1'b1;
				end
				IDX_ALARM_ID: begin
					alarm_cob_q <= wval;
					alarm_set_q <= 1'b1;
				end
				default: sync_q <= sync_q;
			endcase
		end
	end

	assign tx_valid = tx_valid_q;
	assign tx_frame = tx_frame_q;
	assign outputs_error = oerr_q;
	assign guarding_active = g_q == G_WATCH;

	sequence s_poll_free;
		poll && !tx_valid_q && !ap_q && !sp_q && !gp_q;
	endsequence

	sequence s_sdo_write;
		sdo_req && is_wr && hit && rw;
	endsequence

	poll_answer_a: assert property (s_poll_free |-> ##2
		tx_valid_q && tx_frame_q.id == $past(guard_id, 2))
		else $error("poll not answered in two cycles");
	state_code_a: assert property ($rose(tx_valid_q)
		&& tx_frame_q.dlc == GUARD_DLC |-> tx_frame_q.data[6:0]
		== ($past(operational) ? ST_OPER : ST_PREOP))
		else $error("wrong state code in reply");
	toggle_bit_a: assert property (ld_g && !expire |=>
		tx_frame_q.data[7] == !toggle_q)
		else $error("reply toggle does not match");
	lost_entry_a: assert property (expire |=>
		!toggle_q && oerr_q && g_q == G_LOST && ap_q)
		else $error("timeout did not enter lost state");
	alarm_frame_a: assert property (ld_a |=>
		tx_frame_q.data == ALARM_DATA && tx_frame_q.dlc == SDO_DLC)
		else $error("alarm frame content wrong");
	no_watch_a: assert property ((!sup_on) [*2]
		|-> !$rose(ap_q))
		else $error("alarm raised with supervision off");
	timer_clear_a: assert property (poll |=>
		ms_q == 24'h00_0000 && pre_q == 32'h0000_0000)
		else $error("poll did not restart timer");
	idle_quiet_a: assert property (g_q == G_IDLE
		|-> !oerr_q && !ap_q)
		else $error("supervision before first poll");
	sdo_ack_a: assert property (s_sdo_write |=>
		sp_q && sdo_rsp_q[7:0] == RSP_WR)
		else $error("write not acknowledged");
endmodule
`default_nettype wire

// file: nmt_master_model.sv
// Behavioural network master that polls the node and runs SDO transfers
`timescale 1ns/1ns
`default_nettype none
module nmt_master_model import guard_pkg::*; (
	input wire logic clk,
	input wire logic tx_valid,
	input wire can_frame_t tx_frame,
	output logic tx_ready,
	output logic rx_valid,
	output can_frame_t rx_frame
);
	int stall = 0;
	logic exp_tog = 1'b0;
	// Idle bus at time zero
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_frame = '0;
	end
	// One-cycle frame; the released lines then show the inverse value
	task automatic send(input can_frame_t f);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_frame <= f;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_frame <= ~f;
	endtask
	// Take one node frame; ready is raised late when a stall is asked
	task automatic take(input int limit, output can_frame_t f,
			output logic seen);
		int n;
		seen = 1'b0;
		f = '0;
		for (n = 0; n < limit && !seen; n++) begin
			@(negedge clk);
			seen = (tx_valid === 1'b1);
		end
		if (seen) begin
			f = tx_frame;
			repeat (stall) @(posedge clk);
			@(posedge clk);
			tx_ready <= 1'b1;
			@(posedge clk);
			tx_ready <= 1'b0;
		end
	endtask
	// Expect toggle 0 in the next reply
	task automatic resync();
		exp_tog = 1'b0;
	endtask
	// Remote request on the guard id; reply judged on toggle and state
	task automatic poll(input logic [10:0] gid, input logic [6:0] st,
			output logic ok);
		can_frame_t f;
		logic seen;
		send({gid, 1'b1, 4'h0, 64'h0});
		take(20, f, seen);
		ok = seen && f.id === gid && f.dlc === 4'h1
			&& f.data[7:0] === {exp_tog, st};
		exp_tog = ~exp_tog;
	endtask
	// Eight-byte request to the node, subindex and index in at
	task automatic sdo(input logic [10:0] n, input logic [7:0] cmd,
			input logic [23:0] at, input logic [31:0] val,
			output can_frame_t f);
		logic seen;
		send({SDO_RX_BASE + n, 1'b0, SDO_DLC, val, at, cmd});
		take(20, f, seen);
	endtask
endmodule
`default_nettype wire

// file: node_life_guarding_test.sv
// Self-checking bench for the guarding responder and its objects
`timescale 1ns/1ns
`default_nettype none
module node_life_guarding_test import guard_pkg::*; ;
	localparam logic [10:0] NODE = 11'h005;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] station_number = NODE[6:0];
	logic operational = 1'b0;
	logic rx_valid, tx_valid, tx_ready, outputs_error, guarding_active;
	can_frame_t rx_frame, tx_frame;
	int bad_count = 0;
	int samples_checked = 0;
	// 125 MHz clock
	always #4 clk = ~clk;
	node_life_guarding #(.CYC_MS(10)) dut_u (.clk(clk), .arst_n(arst_n),
		.station_number(station_number), .operational(operational),
		.rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_frame(tx_frame),
		.outputs_error(outputs_error), .guarding_active(guarding_active));
	nmt_master_model master_u (.clk(clk), .tx_valid(tx_valid),
		.tx_frame(tx_frame), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_frame(rx_frame));
	// Counts of comparisons, then the verdict
	task automatic complete_run();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Reset held four cycles; outputs must sit idle meanwhile
	task automatic reset_dut();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		check(64'({tx_valid, outputs_error, guarding_active}), 64'h0);
		arst_n <= 1'b1;
		master_u.resync();
		@(posedge clk);
	endtask
	// SDO request on subindex and index, full comparison of the answer
	task automatic xfer_at(input logic [7:0] cmd, input logic [23:0] at,
			input logic [31:0] val, input logic [7:0] rsp,
			input logic [31:0] exp);
		can_frame_t f;
		master_u.sdo(NODE, cmd, at, val, f);
		check(64'({f.id, f.dlc}), 64'({11'h585, 4'h8}));
		check(f.data, {exp, at, rsp});
	endtask
	// Same request on subindex zero
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] idx,
			input logic [31:0] val, input logic [7:0] rsp,
			input logic [31:0] exp);
		xfer_at(cmd, {8'h00, idx}, val, rsp, exp);
	endtask
	task automatic poll_ok(input logic [10:0] gid, input logic [6:0] st,
			input logic exp);
		logic ok;
		master_u.poll(gid, st, ok);
		check(64'(ok), 64'(exp));
	endtask
	// Reset values, access kinds, unknown object and read-only refusal
	task automatic t_dict();
		reset_dut();
		xfer(8'h40, 16'h1001, 0, 8'h4f, 32'h0000_0000);
		xfer(8'h40, 16'h1003, 0, 8'h4f, 32'h0000_000a);
		xfer(8'h40, 16'h1004, 0, 8'h43, 32'h0005_000a);
		xfer(8'h40, 16'h1005, 0, 8'h43, 32'h0000_0080);
		xfer(8'h40, 16'h100b, 0, 8'h43, 32'h0000_0005);
		xfer(8'h40, 16'h100c, 0, 8'h4b, 32'h0000_03e8);
		xfer(8'h40, 16'h100d, 0, 8'h4f, 32'h0000_0003);
		xfer(8'h40, 16'h100e, 0, 8'h43, 32'h0000_0705);
		xfer(8'h40, 16'h100f, 0, 8'h43, 32'h0001_0001);
		xfer(8'h40, 16'h1014, 0, 8'h43, 32'h0000_0085);
		xfer(8'h23, 16'h1014, 32'h0000_00ab, 8'h60, 0);
		xfer(8'h40, 16'h1014, 0, 8'h43, 32'h0000_00ab);
		xfer(8'h40, 16'h1234, 0, 8'h80, 32'h0602_0000);
		xfer(8'h23, 16'h1001, 5, 8'h80, 32'h0601_0002);
		xfer_at(8'h40, 24'h03_1003, 0, 8'h43, 32'h0000_0000);
		xfer_at(8'h40, 24'h01_1005, 0, 8'h80, 32'h0602_0000);
		xfer(8'h01, 16'h1005, 0, 8'h80, 32'h0504_0001);
	endtask
	// State codes, toggle sequence and a rewritten guard id
	task automatic t_guard();
		reset_dut();
		operational <= 1'b0;
		poll_ok(11'h705, 7'h04, 1'b1);
		operational <= 1'b1;
		poll_ok(11'h705, 7'h05, 1'b1);
		poll_ok(11'h705, 7'h05, 1'b1);
		check(64'(guarding_active), 64'h1);
		xfer(8'h23, 16'h100e, 32'h0000_0123, 8'h60, 0);
		poll_ok(11'h123, 7'h05, 1'b1);
		poll_ok(11'h705, 7'h05, 1'b0);
		operational <= 1'b0;
	endtask
	// Timeout of 5 ms times 2 = 100 clocks; alarm, error, restart
	task automatic t_super(input logic [10:0] aid);
		can_frame_t f;
		logic seen;
		reset_dut();
		xfer(8'h2b, 16'h100c, 32'h0000_0005, 8'h60, 0);
		xfer(8'h2f, 16'h100d, 32'h0000_0002, 8'h60, 0);
		if (aid != 11'h085) xfer(8'h23, 16'h1014, 32'(aid), 8'h60, 0);
		repeat (150) @(posedge clk);
		check(64'({outputs_error, tx_valid}), 64'h0);
		poll_ok(11'h705, 7'h04, 1'b1);
		repeat (3) begin
			repeat (80) @(posedge clk);
			poll_ok(11'h705, 7'h04, 1'b1);
		end
		repeat (85) @(posedge clk);
		check(64'(outputs_error), 64'h0);
		master_u.stall = 3;
		master_u.take(40, f, seen);
		master_u.stall = 0;
		check(64'({seen, f.id, f.rtr, f.dlc}), 64'({1'b1, aid, 5'h08}));
		check(f.data, 64'h0000_0010_0001_0010);
		check(64'(outputs_error), 64'h1);
		xfer(8'h40, 16'h1001, 0, 8'h4f, 32'h0000_0011);
		master_u.resync();
		poll_ok(11'h705, 7'h04, 1'b1);
		check(64'(outputs_error), 64'h0);
	endtask
	// A zero interval or a zero multiplier leaves the master unwatched
	task automatic t_off();
		int k;
		for (k = 0; k < 2; k++) begin
			reset_dut();
			xfer(8'h2b, 16'h100c, 32'(k * 5), 8'h60, 0);
			xfer(8'h2f, 16'h100d, 32'((1 - k) * 2), 8'h60, 0);
			poll_ok(11'h705, 7'h04, 1'b1);
			repeat (300) @(posedge clk);
			check(64'({outputs_error, tx_valid}), 64'h0);
		end
	endtask
	// Main sequence
	initial begin
		t_dict();
		t_guard();
		t_super(11'h085);
		t_super(11'h0ab);
		t_off();
		complete_run();
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire
